// file: flash_guard_pkg.sv
package flash_guard_pkg;

	// --------------------------------------------------------------------
	// Flash geometry
	// --------------------------------------------------------------------
	localparam int          ADDR_W         = 16;
	localparam int          PAGE_SHIFT     = 10;
	localparam int          PAGE_W         = ADDR_W - PAGE_SHIFT;
	localparam logic [15:0] LOCK_BYTE_ADDR = 16'hFBFF;
	localparam logic [15:0] RESERVED_BASE  = 16'hFC00;
	localparam logic [15:0] PART_ID_ADDR   = 16'hFFFE;
	localparam logic [5:0]  LOCK_PAGE      = 6'h3E;
	localparam logic [7:0]  ERASED_BYTE    = 8'hFF;

	// --------------------------------------------------------------------
	// Key sequence and control bit positions
	// --------------------------------------------------------------------
	localparam logic [7:0]  KEY_FIRST      = 8'hA5;
	localparam logic [7:0]  KEY_SECOND     = 8'hF1;
	localparam int          WE_BIT         = 0;
	localparam int          EE_BIT         = 1;
	localparam int          SCRATCH_BIT    = 2;
	localparam logic [2:0]  CTRL_RESET     = 3'h0;
	localparam int          PORF_BIT       = 1;

	// --------------------------------------------------------------------
	// Key sequencer states and access kinds
	// --------------------------------------------------------------------
	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_HALF,
		KEY_OPEN,
		KEY_DEAD
	} key_state_e;

	typedef enum logic [1:0] {
		OP_READ,
		OP_WRITE,
		OP_ERASE
	} op_kind_e;

endpackage : flash_guard_pkg

// file: flash_key_seq.sv
`timescale 1ns/1ps

// --------------------------------------------------------------------
// Two-key unlock sequencer for firmware flash modification.
// --------------------------------------------------------------------
module flash_key_seq (
	input  wire logic ref_clk_i,
	input  wire logic reset_i,
	input  wire logic key_wr_i,
	input  wire logic [7:0] key_data_i,
	input  wire logic consume_i,
	output logic      key_open_o,
	output logic      key_dead_o
);

	flash_guard_pkg::key_state_e state_q, state_d;

	// Any wrong key, or a modify before the keys, locks out until reset.
	always_comb begin
		state_d = state_q;
		case (state_q)
			flash_guard_pkg::KEY_IDLE: begin
				if (consume_i)
					state_d = flash_guard_pkg::KEY_DEAD;
				else if (key_wr_i)
					state_d = (key_data_i == flash_guard_pkg::KEY_FIRST) ?
						flash_guard_pkg::KEY_HALF : flash_guard_pkg::KEY_DEAD;
			end
			flash_guard_pkg::KEY_HALF: begin
				if (consume_i)
					state_d = flash_guard_pkg::KEY_DEAD;
				else if (key_wr_i)
					state_d = (key_data_i == flash_guard_pkg::KEY_SECOND) ?
						flash_guard_pkg::KEY_OPEN : flash_guard_pkg::KEY_DEAD;
			end
			flash_guard_pkg::KEY_OPEN: begin
				// The lock rearms after every single modify request; reads do not consume it.
				if (consume_i)
					state_d = flash_guard_pkg::KEY_IDLE;
				else if (key_wr_i)
					state_d = flash_guard_pkg::KEY_DEAD;
			end
			flash_guard_pkg::KEY_DEAD: state_d = flash_guard_pkg::KEY_DEAD;
			default: state_d = flash_guard_pkg::KEY_DEAD;
		endcase
	end

	// Reset (including the flash-error reset) clears the sequence.
	always_ff @(posedge ref_clk_i) begin
		if (reset_i)
			state_q <= flash_guard_pkg::KEY_IDLE;
		else
			state_q <= state_d;
	end

	assign key_open_o = (state_q == flash_guard_pkg::KEY_OPEN);
	assign key_dead_o = (state_q == flash_guard_pkg::KEY_DEAD);

	// --------------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------------
	a_dead_sticks: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		key_dead_o |=> key_dead_o)
		else $error("key lockout left without reset");
	// Key writes may be spread out in time, so the check starts from the
	// half-open state rather than from two back-to-back writes.
	a_keys_open: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		(state_q == flash_guard_pkg::KEY_HALF && key_wr_i && !consume_i
		 && key_data_i == flash_guard_pkg::KEY_SECOND) |=> key_open_o)
		else $error("correct key pair did not open");
	c_keys_open: cover property (@(posedge ref_clk_i) key_open_o);

endmodule : flash_key_seq

// file: flash_security_guard.sv
`timescale 1ns/1ps

// Summary of operation
// - Reserved area: debug refused, firmware causes error reset.
// - Error reset resets device, sets sticky flag.
// - Debug full erase wipes all pages, unlocks.
// - Any page locked locks the lock page.
// - Written lock byte is unchangeable except full erase.
// - New lock value applies after next reset.
// - Scratchpad locked when all pages locked.
// - Full erase also erases the scratchpad.
// - Part code readable at fixed flash address.
// - Modify needs supply monitor and its reset.
// - Power-on reset enables monitor and reset source.
// - Interrupts raised during modify stay pending.
// - Write enable is control bit 0.
// - Two ordered keys precede each modify.
// - Lock n pages from 0, n = ~lock byte.
// - Erase plus write enable makes writes erase pages.
module flash_security_guard #(
	parameter logic [7:0] PART_ID = 8'h5A // Arbitrary neutral value.
) (
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	input  wire logic        por_i,
	// Firmware request.
	input  wire logic        fw_req_i,
	input  wire logic [1:0]  fw_op_i,
	input  wire logic [15:0] fw_addr_i,
	input  wire logic [15:0] fw_pc_i,
	// Debug port request.
	input  wire logic        dbg_req_i,
	input  wire logic [1:0]  dbg_op_i,
	input  wire logic [15:0] dbg_addr_i,
	input  wire logic        debug_full_erase_i,
	// Control writes.
	input  wire logic        ctrl_wr_i,
	input  wire logic [2:0]  ctrl_data_i,
	input  wire logic        key_wr_i,
	input  wire logic [7:0]  key_data_i,
	input  wire logic        mon_wr_i,
	input  wire logic        mon_en_i,
	input  wire logic        mon_rst_en_i,
	input  wire logic        rsrc_wr_i,
	input  wire logic [7:0]  rsrc_data_i,
	// Flash side.
	input  wire logic [7:0]  lock_byte_i,
	input  wire logic        flash_busy_i,
	input  wire logic        irq_i,
	// Results.
	output logic             grant_o,
	output logic             refuse_o,
	output logic             do_page_erase_o,
	output logic             do_full_erase_o,
	output logic             id_sel_o,
	output logic [7:0]       part_id_o,
	output logic             flash_error_reset_o,
	output logic             flash_error_flag_o,
	output logic [2:0]       program_store_control_o,
	output logic             mon_en_o,
	output logic             mon_rst_en_o,
	output logic             irq_pending_o
);

	// --------------------------------------------------------------------
	// Page lock decode
	// --------------------------------------------------------------------
	function automatic logic page_locked(input logic [15:0] a,
		input logic [7:0] n, input logic scratch);
		logic [5:0] pg;
		pg = a[15:10];
		if (scratch)
			page_locked = (n == 8'hFF) || (n >= 8'h3E);
		else if (pg == flash_guard_pkg::LOCK_PAGE)
			page_locked = (n != 8'h00);
		else
			page_locked = ({2'h0, pg} < n);
	endfunction : page_locked

	logic [7:0] lock_n_q, lock_n_d;
	logic [2:0] ctrl_q, ctrl_d;
	logic       flag_q, flag_d, mon_q, mon_d, mrst_q, mrst_d;
	logic       err_q, err_d, pend_q, pend_d;
	logic       key_open, key_dead, consume, fw_mod, fw_bad, scratch;
	logic       fw_locked, tgt_locked, in_resv, lock_pg, dbg_bad;
	logic       grant_d, refuse_d, perase_d, ferase_d, idsel_d;
	logic       grant_q, refuse_q, perase_q, ferase_q, idsel_q;

	flash_key_seq u_keys (
		.ref_clk_i  (ref_clk_i),
		.reset_i    (reset_i),
		.key_wr_i   (key_wr_i),
		.key_data_i (key_data_i),
		.consume_i  (consume),
		.key_open_o (key_open),
		.key_dead_o (key_dead)
	);

	// --------------------------------------------------------------------
	// Request judgement
	// --------------------------------------------------------------------
	always_comb begin
		scratch    = ctrl_q[flash_guard_pkg::SCRATCH_BIT];
		in_resv    = !scratch && (fw_addr_i >= flash_guard_pkg::RESERVED_BASE);
		lock_pg    = !scratch && (fw_addr_i[15:10] == flash_guard_pkg::LOCK_PAGE);
		fw_locked  = page_locked(fw_pc_i, lock_n_q, 1'b0);
		tgt_locked = page_locked(fw_addr_i, lock_n_q, scratch);
		fw_mod     = fw_req_i && (fw_op_i != flash_guard_pkg::OP_READ);
		consume    = fw_mod;
		fw_bad     = 1'b0;
		if (fw_req_i) begin
			// Only a read of the part code byte is let through here.
			if (in_resv && (fw_mod
			    || fw_addr_i != flash_guard_pkg::PART_ID_ADDR))
				fw_bad = 1'b1;
			else if (tgt_locked && !fw_locked)
				fw_bad = 1'b1;
			if (fw_mod) begin
				// Lock page cannot be erased, nor lock byte rewritten.
				if (lock_pg && (fw_op_i == flash_guard_pkg::OP_ERASE
				    || ctrl_q[flash_guard_pkg::EE_BIT]))
					fw_bad = 1'b1;
				if (fw_addr_i == flash_guard_pkg::LOCK_BYTE_ADDR && !scratch
				    && lock_byte_i != flash_guard_pkg::ERASED_BYTE)
					fw_bad = 1'b1;
				if (!(mon_q && mrst_q))
					fw_bad = 1'b1;
			end
		end
		dbg_bad = dbg_req_i && ((dbg_addr_i >= flash_guard_pkg::RESERVED_BASE)
			|| (page_locked(dbg_addr_i, lock_n_q, 1'b0)));
		idsel_d  = fw_req_i && fw_op_i == flash_guard_pkg::OP_READ
			&& fw_addr_i == flash_guard_pkg::PART_ID_ADDR;
		grant_d  = (fw_req_i && !fw_bad && (!fw_mod || (key_open
			&& !key_dead && ctrl_q[flash_guard_pkg::WE_BIT])))
			|| (dbg_req_i && !dbg_bad);
		refuse_d = (dbg_req_i && dbg_bad)
			|| (fw_mod && !fw_bad && !grant_d);
		perase_d = fw_mod && grant_d && ctrl_q[flash_guard_pkg::EE_BIT];
		ferase_d = debug_full_erase_i;
		err_d    = fw_bad;
	end

	// --------------------------------------------------------------------
	// Control state
	// --------------------------------------------------------------------
	always_comb begin
		ctrl_d   = ctrl_q;
		lock_n_d = lock_n_q;
		flag_d   = flag_q;
		mon_d    = mon_q;
		mrst_d   = mrst_q;
		pend_d   = pend_q;
		if (ctrl_wr_i)
			ctrl_d = ctrl_data_i;
		if (mon_wr_i) begin
			mon_d  = mon_en_i;
			mrst_d = mon_rst_en_i;
		end
		if (rsrc_wr_i)
			flag_d = 1'b0; // Direct writes clear the cause bits.
		if (fw_bad)
			flag_d = 1'b1; // Set wins over a clear.
		if (debug_full_erase_i)
			lock_n_d = 8'h00;
		// Interrupts arriving during a modify wait until it ends.
		if (irq_i && (flash_busy_i || ctrl_q[flash_guard_pkg::WE_BIT]))
			pend_d = 1'b1;
		else if (!flash_busy_i)
			pend_d = 1'b0;
	end

	// Reset samples the lock byte so later edits wait for the next reset.
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ctrl_q   <= flash_guard_pkg::CTRL_RESET;
			lock_n_q <= ~lock_byte_i;
			pend_q   <= 1'b0;
			err_q    <= 1'b0;
			grant_q  <= 1'b0;
			refuse_q <= 1'b0;
			perase_q <= 1'b0;
			ferase_q <= 1'b0;
			idsel_q  <= 1'b0;
			if (por_i) begin
				mon_q  <= 1'b1;
				mrst_q <= 1'b1;
				flag_q <= 1'b0;
			end else if (err_q) begin
				flag_q <= 1'b1;
			end
		end else begin
			ctrl_q   <= ctrl_d;
			lock_n_q <= lock_n_d;
			flag_q   <= flag_d;
			mon_q    <= mon_d;
			mrst_q   <= mrst_d;
			pend_q   <= pend_d;
			err_q    <= err_d;
			grant_q  <= grant_d;
			refuse_q <= refuse_d;
			perase_q <= perase_d;
			ferase_q <= ferase_d;
			idsel_q  <= idsel_d;
		end
	end

	assign grant_o                 = grant_q;
	assign refuse_o                = refuse_q;
	assign do_page_erase_o         = perase_q;
	assign do_full_erase_o         = ferase_q;
	assign id_sel_o                = idsel_q;
	assign part_id_o               = PART_ID;
	assign flash_error_reset_o     = err_q;
	assign flash_error_flag_o      = flag_q;
	assign program_store_control_o = ctrl_q;
	assign mon_en_o                = mon_q;
	assign mon_rst_en_o            = mrst_q;
	assign irq_pending_o           = pend_q;

	// --------------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------------
	// The error pulse comes back as a system reset, so the checks that expect
	// it test reset in their antecedent rather than being disabled by it.
	a_resv_fw_err: assert property (
		@(posedge ref_clk_i) (!reset_i && fw_req_i && !scratch
		 && fw_addr_i >= flash_guard_pkg::RESERVED_BASE
		 && (fw_mod || fw_addr_i != flash_guard_pkg::PART_ID_ADDR))
		|=> flash_error_reset_o)
		else $error("reserved access did not raise error reset");
	a_resv_dbg: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		(dbg_req_i && dbg_addr_i >= flash_guard_pkg::RESERVED_BASE)
		|=> refuse_o && !grant_o)
		else $error("debug reserved access not refused");
	a_err_flag: assert property (
		@(posedge ref_clk_i) flash_error_reset_o |-> flash_error_flag_o)
		else $error("error reset without flag");
	a_mon_needed: assert property (
		@(posedge ref_clk_i)
		(!reset_i && fw_mod && !(mon_en_o && mon_rst_en_o))
		|=> flash_error_reset_o)
		else $error("modify with monitor off not trapped");
	a_we_needed: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		(fw_mod && !program_store_control_o[0] && !dbg_req_i)
		|=> !grant_o)
		else $error("modify granted without write enable");
	a_full_erase: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		debug_full_erase_i |=> do_full_erase_o ##1 (lock_n_q == 8'h00))
		else $error("full erase did not unlock");
	a_lock_stable: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		!debug_full_erase_i |=> $stable(lock_n_q))
		else $error("lock state changed before reset");
	a_irq_hold: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		(irq_i && flash_busy_i) |=> irq_pending_o)
		else $error("interrupt during modify not held");
	c_page_erase: cover property (@(posedge ref_clk_i) do_page_erase_o);
	c_err_reset: cover property (@(posedge ref_clk_i) flash_error_reset_o);
	c_part_id: cover property (@(posedge ref_clk_i) id_sel_o);

endmodule : flash_security_guard

// file: flash_host_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Firmware and debug requester facing the guard
// ------------------------------------------------------------
module flash_host_model (
	input  wire logic   ref_clk_i,
	output logic        fw_req_o,
	output logic        dbg_req_o,
	output logic        key_wr_o,
	output logic        ctrl_wr_o,
	output logic        rsrc_wr_o,
	output logic [1:0]  op_o,
	output logic [15:0] addr_o,
	output logic [15:0] pc_o,
	output logic [7:0]  data_o,
	output logic [7:0]  rsrc_o
);
	// Reset source writes are plain stores with the power flag set.
	assign rsrc_o = 8'h01 << flash_guard_pkg::PORF_BIT;

	// Everything idle at time zero.
	initial begin
		{rsrc_wr_o, ctrl_wr_o, key_wr_o, dbg_req_o, fw_req_o} = 5'h00;
		op_o = 2'h0;
		addr_o = 16'h0000;
		pc_o = 16'h0000;
		data_o = 8'h00;
	end

	// One strobe for one edge; released op, address and data lines show the inverse so that
	// a design that samples late never sees a lucky stale value.
	task automatic pulse(input logic [4:0] sel, input logic [1:0] op,
		input logic [15:0] a, input logic [15:0] pc, input logic [7:0] v);
		@(negedge ref_clk_i);
		{rsrc_wr_o, ctrl_wr_o, key_wr_o, dbg_req_o, fw_req_o} = sel;
		op_o = op;
		addr_o = a;
		pc_o = pc;
		data_o = v;
		@(negedge ref_clk_i);
		{rsrc_wr_o, ctrl_wr_o, key_wr_o, dbg_req_o, fw_req_o} = 5'h00;
		op_o = ~op;
		addr_o = ~a;
		data_o = ~v;
	endtask : pulse
endmodule : flash_host_model

// file: tb_flash_security_guard.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Self-checking bench for the flash guard
// ------------------------------------------------------------
module tb_flash_security_guard;
	logic        ref_clk_i, reset_i, rst_q, por_i, debug_full_erase_i;
	logic        mon_wr_i, mon_en_i, mon_rst_en_i, flash_busy_i, irq_i;
	logic        fw_req_i, dbg_req_i, key_wr_i, ctrl_wr_i, rsrc_wr_i;
	logic [1:0]  fw_op_i;
	logic [15:0] fw_addr_i, fw_pc_i, pc;
	logic [7:0]  key_data_i, rsrc_data_i, lock_byte_i, part_id_o, lock_n;
	logic        grant_o, refuse_o, do_page_erase_o, do_full_erase_o;
	logic        id_sel_o, flash_error_reset_o, flash_error_flag_o;
	logic        mon_en_o, mon_rst_en_o, irq_pending_o;
	logic [2:0]  program_store_control_o;
	logic [31:0] seed;
	int          miscompares, n_tests;

	// Part code given to the design; the value is arbitrary.
	localparam logic [7:0] ID_CODE = 8'h3C;

	// The error pulse is fed back as a system reset, as on the chip.
	assign reset_i = rst_q | flash_error_reset_o;

	flash_host_model u_host (
		.ref_clk_i, .fw_req_o(fw_req_i), .dbg_req_o(dbg_req_i),
		.key_wr_o(key_wr_i), .ctrl_wr_o(ctrl_wr_i), .rsrc_wr_o(rsrc_wr_i),
		.op_o(fw_op_i), .addr_o(fw_addr_i), .pc_o(fw_pc_i),
		.data_o(key_data_i), .rsrc_o(rsrc_data_i)
	);

	flash_security_guard #(.PART_ID(ID_CODE)) DUT (
		.ref_clk_i, .reset_i, .por_i, .fw_req_i, .fw_op_i, .fw_addr_i,
		.fw_pc_i, .dbg_req_i, .dbg_op_i(fw_op_i), .dbg_addr_i(fw_addr_i),
		.debug_full_erase_i, .ctrl_wr_i, .ctrl_data_i(key_data_i[2:0]),
		.key_wr_i, .key_data_i, .mon_wr_i, .mon_en_i, .mon_rst_en_i,
		.rsrc_wr_i, .rsrc_data_i, .lock_byte_i, .flash_busy_i, .irq_i,
		.grant_o, .refuse_o, .do_page_erase_o, .do_full_erase_o, .id_sel_o,
		.part_id_o, .flash_error_reset_o, .flash_error_flag_o,
		.program_store_control_o, .mon_en_o, .mon_rst_en_o, .irq_pending_o
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wrap_up;
		if (miscompares == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	// Debug refusal: reserved area, the first n pages, and the lock page
	// whenever any page is locked.
	function automatic logic refused(input logic [15:0] ad, input logic [7:0] n);
		return ad >= flash_guard_pkg::RESERVED_BASE || ad[15:10] < n ||
			(n != 8'h00 && ad[15:10] == flash_guard_pkg::LOCK_PAGE);
	endfunction : refused

	task automatic fw(input logic [1:0] op, input logic [15:0] ad);
		u_host.pulse(5'h01, op, ad, pc, 8'h00);
	endtask : fw

	task automatic dbg(input logic [15:0] ad);
		u_host.pulse(5'h02, 2'h0, ad, pc, 8'h00);
	endtask : dbg

	task automatic key(input logic [7:0] v);
		u_host.pulse(5'h04, 2'h0, 16'h0000, pc, v);
	endtask : key

	task automatic ctrl(input logic [2:0] v);
		u_host.pulse(5'h08, 2'h0, 16'h0000, pc, {5'h00, v});
	endtask : ctrl

	task automatic mon(input logic en, input logic rst);
		@(negedge ref_clk_i);
		mon_wr_i = 1'b1;
		mon_en_i = en;
		mon_rst_en_i = rst;
		@(negedge ref_clk_i);
		mon_wr_i = 1'b0;
	endtask : mon

	// A plain reset may leave the monitor off, so it is turned back on.
	task automatic sys_reset(input logic p);
		@(negedge ref_clk_i);
		rst_q = 1'b1;
		por_i = p;
		repeat (3) @(negedge ref_clk_i);
		rst_q = 1'b0;
		por_i = 1'b0;
		lock_n = ~lock_byte_i;
		if (!p) begin
			mon(1'b1, 1'b1);
		end
	endtask : sys_reset

	task automatic fault(input string what);
		check(what, flash_error_reset_o, 1'b1);
		@(negedge ref_clk_i);
		lock_n = ~lock_byte_i;
		check("error flag", flash_error_flag_o, 1'b1);
		check("controls cleared", program_store_control_o, 3'h0);
		mon(1'b1, 1'b1);
		u_host.pulse(5'h10, 2'h0, 16'h0000, pc, 8'h00);
		check("flag cleared", flash_error_flag_o, 1'b0);
	endtask : fault

	task automatic rand_dbg;
		logic [15:0] ad;
		repeat (16) begin
			seed = xs(seed);
			ad = seed[15:0] & 16'hFFFD;
			dbg(ad);
			check("debug access", {grant_o, refuse_o},
				{~refused(ad, lock_n), refused(ad, lock_n)});
		end
	endtask : rand_dbg

	// ------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ------------------------------------------------------------
	// The bench never switches clocks, so no modify rides an oscillator
	// change.
	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end

	// About 200 cycles are expected; ten times that means a hang.
	initial begin
		#10000;
		miscompares++;
		wrap_up();
	end

	initial begin
		miscompares = 0;
		n_tests = 0;
		seed = 32'h00013DD6;
		{rst_q, por_i} = 2'h3;
		{debug_full_erase_i, mon_wr_i, flash_busy_i, irq_i} = 4'h0;
		{mon_en_i, mon_rst_en_i} = 2'h3;
		lock_byte_i = 8'hFF;
		pc = 16'h0000;
		sys_reset(1'b1);
		check("monitor on", {mon_en_o, mon_rst_en_o}, 2'h3);
		check("flag after power-on", flash_error_flag_o, 1'b0);
		ctrl(3'h1);
		check("write enable bit", program_store_control_o, 3'h1);
		key(flash_guard_pkg::KEY_FIRST);
		key(flash_guard_pkg::KEY_SECOND);
		fw(flash_guard_pkg::OP_WRITE, 16'h1234);
		check("keyed write", grant_o, 1'b1);
		fw(flash_guard_pkg::OP_WRITE, 16'h1235);
		check("unkeyed write", refuse_o, 1'b1);
		key(flash_guard_pkg::KEY_FIRST);
		key(flash_guard_pkg::KEY_SECOND);
		fw(flash_guard_pkg::OP_WRITE, 16'h1236);
		check("keys after lockout", refuse_o, 1'b1);
		sys_reset(1'b0);
		key(flash_guard_pkg::KEY_FIRST);
		key(flash_guard_pkg::KEY_SECOND);
		fw(flash_guard_pkg::OP_WRITE, 16'h1234);
		check("write enable clear", refuse_o, 1'b1);
		sys_reset(1'b0);
		ctrl(3'h1);
		key(flash_guard_pkg::KEY_SECOND);
		key(flash_guard_pkg::KEY_FIRST);
		fw(flash_guard_pkg::OP_WRITE, 16'h1234);
		check("reversed keys", refuse_o, 1'b1);
		sys_reset(1'b0);
		ctrl(3'h3);
		key(flash_guard_pkg::KEY_FIRST);
		key(flash_guard_pkg::KEY_SECOND);
		fw(flash_guard_pkg::OP_WRITE, 16'h2345);
		check("erase by write", do_page_erase_o, 1'b1);
		fw(flash_guard_pkg::OP_READ, flash_guard_pkg::PART_ID_ADDR);
		check("part select", id_sel_o, 1'b1);
		check("part code", part_id_o, ID_CODE);
		dbg(flash_guard_pkg::RESERVED_BASE);
		check("debug reserved", refuse_o, 1'b1);
		rand_dbg();
		fw(flash_guard_pkg::OP_READ, 16'hFC10);
		fault("firmware reserved");
		mon(1'b0, 1'b1);
		check("monitor off", mon_en_o, 1'b0);
		ctrl(3'h1);
		key(flash_guard_pkg::KEY_FIRST);
		key(flash_guard_pkg::KEY_SECOND);
		fw(flash_guard_pkg::OP_WRITE, 16'h1000);
		fault("write, monitor off");
		// Interrupts are raised only while the write enable is clear.
		flash_busy_i = 1'b1;
		irq_i = 1'b1;
		@(negedge ref_clk_i);
		irq_i = 1'b0;
		@(negedge ref_clk_i);
		check("irq held", irq_pending_o, 1'b1);
		flash_busy_i = 1'b0;
		lock_byte_i = 8'hFD;
		sys_reset(1'b0);
		rand_dbg();
		dbg(16'hFB00);
		check("lock page", refuse_o, 1'b1);
		pc = 16'h4000;
		fw(flash_guard_pkg::OP_READ, 16'h0010);
		fault("locked from unlocked");
		ctrl(3'h4);
		fw(flash_guard_pkg::OP_READ, 16'h0010);
		check("scratch open", grant_o, 1'b1);
		pc = 16'h0000;
		ctrl(3'h1);
		key(flash_guard_pkg::KEY_FIRST);
		key(flash_guard_pkg::KEY_SECOND);
		fw(flash_guard_pkg::OP_WRITE, flash_guard_pkg::LOCK_BYTE_ADDR);
		fault("lock byte rewrite");
		@(negedge ref_clk_i);
		debug_full_erase_i = 1'b1;
		@(negedge ref_clk_i);
		debug_full_erase_i = 1'b0;
		lock_byte_i = 8'hFF;
		check("full erase", do_full_erase_o, 1'b1);
		dbg(16'h0010);
		check("erase unlocks", grant_o, 1'b1);
		ctrl(3'h1);
		key(flash_guard_pkg::KEY_FIRST);
		key(flash_guard_pkg::KEY_SECOND);
		fw(flash_guard_pkg::OP_WRITE, flash_guard_pkg::LOCK_BYTE_ADDR);
		check("lock byte write", grant_o, 1'b1);
		lock_byte_i = 8'hFE;
		dbg(16'h0010);
		check("old lock kept", grant_o, 1'b1);
		sys_reset(1'b0);
		dbg(16'h0010);
		check("new lock", refuse_o, 1'b1);
		wrap_up();
	end
endmodule : tb_flash_security_guard
